// ---- core/adc_result_modify.sv ----
`timescale 1ns/1ns
`default_nettype none
module adc_result_modify (
	input wire logic CLOCK_I,
	input wire logic RST_I,
	input wire logic CFG_MAP_WE_I,
	input wire logic CFG_RCR_WE_I,
	input wire logic [1:0] CFG_GROUP_I,
	input wire logic [3:0] CFG_CHANNEL_I,
	input wire logic [3:0] CFG_RESULT_I,
	input wire logic [3:0] CFG_INDEX_I,
	input wire logic [1:0] CFG_MODE_I,
	input wire logic [3:0] CFG_CTRL_I,
	input wire logic [1:0] QUEUE_GROUP_I,
	input wire logic QUEUE_PUSH_I,
	input wire logic [3:0] QUEUE_CHANNEL_I,
	input wire logic QUEUE_REFILL_I,
	input wire logic TRIGGER_I,
	input wire logic TIMER_ENABLE_I,
	input wire logic TIMER_TICK_I,
	input wire logic SYNC_REQ_I,
	input wire logic [1:0] SYNC_GROUP_I,
	input wire logic [3:0] SYNC_CHANNEL_I,
	input wire logic CONV_DONE_I,
	input wire logic [11:0] CONV_DATA_I,
	input wire logic READ_I,
	input wire logic [1:0] READ_GROUP_I,
	input wire logic [3:0] READ_INDEX_I,
	output logic CONV_REQ_O,
	output logic [1:0] CONV_GROUP_O,
	output logic [3:0] CONV_CHANNEL_O,
	output logic BUSY_O,
	output logic [3:0] QUEUE_LEVEL_O,
	output logic READ_ACK_O,
	output logic [15:0] READ_DATA_O,
	output logic READ_VALID_O,
	output logic [3:0] READ_COUNT_O,
	output logic RESULT_EVENT_O,
	output logic [1:0] RESULT_GROUP_O,
	output logic [3:0] RESULT_INDEX_O
);
	localparam int ENTRIES = adc_mod_pkg::GROUPS * adc_mod_pkg::CHANNELS;

	adc_mod_pkg::seq_state_t state, next_state;
	logic [2:0] head, next_head, tail, next_tail;
	logic [3:0] level, next_level;
	logic trig_pend, next_trig_pend, sync_pend, next_sync_pend;
	logic [1:0] sync_group, next_sync_group;
	logic [3:0] sync_channel, next_sync_channel;
	logic [1:0] next_conv_group;
	logic [3:0] next_conv_channel;
	logic next_conv_req, trig, q_we;
	logic [4:0] q_wdata, head_entry;
	logic [4:0] queue_mem [adc_mod_pkg::QUEUE_DEPTH];

	logic [15:0] result_mem [ENTRIES];
	logic [3:0] count_mem [ENTRIES];
	logic [3:0] map_mem [ENTRIES];
	logic [1:0] mode_mem [ENTRIES];
	logic [3:0] ctrl_mem [ENTRIES];
	logic [11:0] hist1_mem [adc_mod_pkg::FILT_SLOTS];
	logic [11:0] hist2_mem [adc_mod_pkg::FILT_SLOTS];
	logic [ENTRIES-1:0] valid_mem, next_valid;
	logic done, hist_we;
	logic [3:0] res_index;
	logic [5:0] res_addr, read_addr, cfg_addr;
	logic [2:0] slot;

	modify_if mif();

	result_calc u_calc (
		.port_m(mif.calc)
	);

	// sequencer: picks sync request or queue head
	always_comb begin
		trig = TRIGGER_I | (TIMER_ENABLE_I & TIMER_TICK_I);
		next_state = state;
		next_head = head;
		next_tail = tail;
		next_level = level;
		next_trig_pend = trig_pend | trig;
		next_sync_pend = sync_pend | SYNC_REQ_I;
		next_sync_group = SYNC_REQ_I ? SYNC_GROUP_I : sync_group;
		next_sync_channel = SYNC_REQ_I ? SYNC_CHANNEL_I : sync_channel;
		next_conv_req = 1'b0;
		next_conv_group = CONV_GROUP_O;
		next_conv_channel = CONV_CHANNEL_O;
		head_entry = queue_mem[head];
		q_we = 1'b0;
		q_wdata = {QUEUE_REFILL_I, QUEUE_CHANNEL_I};
		case (state)
			adc_mod_pkg::SEQ_IDLE: begin
				if (sync_pend) begin
					next_conv_req = 1'b1;
					next_conv_group = sync_group;
					next_conv_channel = sync_channel;
					next_sync_pend = SYNC_REQ_I;
					next_state = adc_mod_pkg::SEQ_WAIT;
				end else if (trig_pend && level != 4'h0) begin
					next_conv_req = 1'b1;
					next_conv_group = QUEUE_GROUP_I;
					next_conv_channel = head_entry[3:0];
					next_head = head + 3'h1;
					next_state = adc_mod_pkg::SEQ_WAIT;
					if (head_entry[4]) begin
						q_we = 1'b1;
						q_wdata = head_entry;
					end else begin
						next_level = level - 4'h1;
						next_trig_pend = trig;
					end
				end
			end
			adc_mod_pkg::SEQ_WAIT: begin
				if (CONV_DONE_I) begin
					next_state = adc_mod_pkg::SEQ_IDLE;
				end
			end
			default: begin
				next_state = adc_mod_pkg::SEQ_IDLE;
			end
		endcase
		if (!q_we && QUEUE_PUSH_I && level != adc_mod_pkg::QUEUE_FULL_LEVEL) begin
			q_we = 1'b1;
			next_level = next_level + 4'h1;
		end
		if (q_we) begin
			next_tail = tail + 3'h1;
		end
	end

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			state <= adc_mod_pkg::SEQ_IDLE;
			head <= 3'h0;
			tail <= 3'h0;
			level <= 4'h0;
			trig_pend <= 1'b0;
			sync_pend <= 1'b0;
			sync_group <= 2'h0;
			sync_channel <= 4'h0;
			CONV_REQ_O <= 1'b0;
			CONV_GROUP_O <= 2'h0;
			CONV_CHANNEL_O <= 4'h0;
			BUSY_O <= 1'b0;
			QUEUE_LEVEL_O <= 4'h0;
		end else begin
			state <= next_state;
			head <= next_head;
			tail <= next_tail;
			level <= next_level;
			trig_pend <= next_trig_pend;
			sync_pend <= next_sync_pend;
			sync_group <= next_sync_group;
			sync_channel <= next_sync_channel;
			CONV_REQ_O <= next_conv_req;
			CONV_GROUP_O <= next_conv_group;
			CONV_CHANNEL_O <= next_conv_channel;
			BUSY_O <= (next_state == adc_mod_pkg::SEQ_WAIT);
			QUEUE_LEVEL_O <= next_level;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (q_we) begin
			queue_mem[tail] <= q_wdata;
		end
	end

	// result path: map, modify, store
	always_comb begin
		done = (state == adc_mod_pkg::SEQ_WAIT) && CONV_DONE_I;
		res_index = map_mem[{CONV_GROUP_O, CONV_CHANNEL_O}];
		res_addr = {CONV_GROUP_O, res_index};
		read_addr = {READ_GROUP_I, READ_INDEX_I};
		cfg_addr = {CFG_GROUP_I, CFG_INDEX_I};
		slot = {CONV_GROUP_O, res_index[adc_mod_pkg::FILTER_SLOT_BIT]};
		mif.mode = adc_mod_pkg::mod_mode_t'(mode_mem[res_addr]);
		mif.ctrl = ctrl_mem[res_addr];
		mif.index = res_index;
		mif.count = count_mem[res_addr];
		mif.raw = CONV_DATA_I;
		mif.hist1 = hist1_mem[slot];
		mif.hist2 = hist2_mem[slot];
		mif.old_value = result_mem[res_addr];
		mif.ref_value = result_mem[{CONV_GROUP_O, adc_mod_pkg::REF_INDEX}];
		hist_we = done && (mif.mode == adc_mod_pkg::MODE_FILTER) &&
			(res_index == adc_mod_pkg::FILTER_INDEX_A ||
			res_index == adc_mod_pkg::FILTER_INDEX_B);
		next_valid = valid_mem;
		if (READ_I) begin
			next_valid[read_addr] = 1'b0;
		end
		if (done && mif.complete) begin
			next_valid[res_addr] = 1'b1;
		end
	end

	// storage for every group and channel; filter history for only two slots per group
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			for (int i = 0; i < ENTRIES; i++) begin
				result_mem[i] <= adc_mod_pkg::RESULT_RESET;
				count_mem[i] <= adc_mod_pkg::COUNT_RESET;
				map_mem[i] <= adc_mod_pkg::REF_INDEX;
				mode_mem[i] <= adc_mod_pkg::MODE_REDUCE;
				ctrl_mem[i] <= adc_mod_pkg::CTRL_RESET;
			end
			for (int i = 0; i < adc_mod_pkg::FILT_SLOTS; i++) begin
				hist1_mem[i] <= adc_mod_pkg::HIST_RESET;
				hist2_mem[i] <= adc_mod_pkg::HIST_RESET;
			end
			valid_mem <= '0;
			READ_ACK_O <= 1'b0;
			READ_DATA_O <= adc_mod_pkg::RESULT_RESET;
			READ_VALID_O <= 1'b0;
			READ_COUNT_O <= adc_mod_pkg::COUNT_RESET;
			RESULT_EVENT_O <= 1'b0;
			RESULT_GROUP_O <= 2'h0;
			RESULT_INDEX_O <= 4'h0;
		end else begin
			valid_mem <= next_valid;
			if (CFG_MAP_WE_I) begin
				map_mem[{CFG_GROUP_I, CFG_CHANNEL_I}] <= CFG_RESULT_I;
			end
			if (CFG_RCR_WE_I) begin
				mode_mem[cfg_addr] <= CFG_MODE_I;
				ctrl_mem[cfg_addr] <= CFG_CTRL_I;
				count_mem[cfg_addr] <= adc_mod_pkg::COUNT_RESET;
			end
			if (done) begin
				result_mem[res_addr] <= mif.result;
				count_mem[res_addr] <= mif.next_count;
			end
			if (hist_we) begin
				hist1_mem[slot] <= CONV_DATA_I;
				hist2_mem[slot] <= hist1_mem[slot];
			end
			READ_ACK_O <= READ_I;
			if (READ_I) begin
				READ_DATA_O <= result_mem[read_addr];
				READ_VALID_O <= valid_mem[read_addr];
				READ_COUNT_O <= count_mem[read_addr];
			end
			RESULT_EVENT_O <= done && mif.complete;
			if (done) begin
				RESULT_GROUP_O <= CONV_GROUP_O;
				RESULT_INDEX_O <= res_index;
			end
		end
	end
endmodule
`default_nettype wire

// ---- common/adc_mod_pkg.sv ----
package adc_mod_pkg;
	localparam int GROUPS = 4;
	localparam int CHANNELS = 16;
	localparam int GROUP_W = 2;
	localparam int CHAN_W = 4;
	localparam int RAW_W = 12;
	localparam int RES_W = 16;
	localparam int CTRL_W = 4;
	localparam int ADDR_W = 6;
	localparam int QUEUE_DEPTH = 8;
	localparam int QPTR_W = 3;
	localparam int QLEVEL_W = 4;
	localparam int FILT_SLOTS = 8;
	localparam logic [3:0] QUEUE_FULL_LEVEL = 4'h8;
	localparam logic [3:0] REF_INDEX = 4'h0;
	localparam logic [3:0] FILTER_INDEX_A = 4'h7;
	localparam logic [3:0] FILTER_INDEX_B = 4'hf;
	localparam int FILTER_SLOT_BIT = 3;
	localparam logic [3:0] IIR_CODE_A = 4'he;
	localparam logic [3:0] IIR_CODE_B = 4'hf;
	localparam logic [15:0] IIR_COEF_A = 16'h0202;
	localparam logic [15:0] IIR_COEF_B = 16'h0304;
	localparam int IIR_SHIFT = 2;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [3:0] COUNT_RESET = 4'h0;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [11:0] HIST_RESET = 12'h000;
	// each entry packs the three fir weights, two bits each: a, b, c
	localparam logic [5:0] FIR_COEF [14] = '{
		6'h24, 6'h18, 6'h21, 6'h15, 6'h12, 6'h34, 6'h28,
		6'h1c, 6'h31, 6'h25, 6'h19, 6'h22, 6'h16, 6'h13};
	typedef enum logic [1:0] {
		MODE_REDUCE = 2'b00,
		MODE_FILTER = 2'b01,
		MODE_DIFF = 2'b10,
		MODE_PLAIN = 2'b11
	} mod_mode_t;
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_WAIT = 2'b01
	} seq_state_t;
endpackage

// ---- common/modify_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface modify_if;
	adc_mod_pkg::mod_mode_t mode;
	logic [3:0] ctrl;
	logic [3:0] index;
	logic [3:0] count;
	logic [11:0] raw;
	logic [11:0] hist1;
	logic [11:0] hist2;
	logic [15:0] old_value;
	logic [15:0] ref_value;
	logic [15:0] result;
	logic [3:0] next_count;
	logic complete;
	modport main(output mode, ctrl, index, count, raw, hist1, hist2,
		old_value, ref_value, input result, next_count, complete);
	modport calc(input mode, ctrl, index, count, raw, hist1, hist2,
		old_value, ref_value, output result, next_count, complete);
endinterface
`default_nettype wire

// ---- core/result_calc.sv ----
`timescale 1ns/1ns
`default_nettype none
module result_calc (
	modify_if.calc port_m
);
	logic [15:0] a;
	logic [15:0] b;
	logic [15:0] c;
	logic [15:0] raw_w;
	logic [15:0] iir_coef;
	logic [15:0] fb;
	logic filterable;

	always_comb begin
		a = 16'h0000;
		b = 16'h0000;
		c = 16'h0000;
		iir_coef = 16'h0000;
		fb = 16'h0000;
		raw_w = {4'h0, port_m.raw};
		filterable = (port_m.index == adc_mod_pkg::FILTER_INDEX_A) ||
			(port_m.index == adc_mod_pkg::FILTER_INDEX_B);
		port_m.result = raw_w;
		port_m.next_count = adc_mod_pkg::COUNT_RESET;
		port_m.complete = 1'b1;
		case (port_m.mode)
			adc_mod_pkg::MODE_REDUCE: begin
				if (port_m.ctrl == adc_mod_pkg::CTRL_RESET) begin
					port_m.result = raw_w;
				end else if (port_m.count == adc_mod_pkg::COUNT_RESET) begin
					port_m.result = raw_w;
					port_m.next_count = port_m.ctrl;
					port_m.complete = 1'b0;
				end else begin
					port_m.result = port_m.old_value + raw_w;
					port_m.next_count = port_m.count - 4'h1;
					port_m.complete = (port_m.count == 4'h1);
				end
			end
			adc_mod_pkg::MODE_FILTER: begin
				if (filterable) begin
					if (port_m.ctrl == adc_mod_pkg::IIR_CODE_A ||
						port_m.ctrl == adc_mod_pkg::IIR_CODE_B) begin
						iir_coef = (port_m.ctrl == adc_mod_pkg::IIR_CODE_A) ?
							adc_mod_pkg::IIR_COEF_A : adc_mod_pkg::IIR_COEF_B;
						a = {8'h00, iir_coef[15:8]};
						b = {8'h00, iir_coef[7:0]};
						fb = (b * {2'b00, port_m.old_value[13:0]}) >>
							adc_mod_pkg::IIR_SHIFT;
						port_m.result = a * raw_w + fb;
					end else begin
						a = {14'h0000, adc_mod_pkg::FIR_COEF[port_m.ctrl][5:4]};
						b = {14'h0000, adc_mod_pkg::FIR_COEF[port_m.ctrl][3:2]};
						c = {14'h0000, adc_mod_pkg::FIR_COEF[port_m.ctrl][1:0]};
						port_m.result = a * raw_w + b * {4'h0, port_m.hist1} +
							c * {4'h0, port_m.hist2};
					end
				end
			end
			adc_mod_pkg::MODE_DIFF: begin
				if (port_m.index != adc_mod_pkg::REF_INDEX) begin
					port_m.result = raw_w - port_m.ref_value;
				end
			end
			default: begin
				port_m.result = raw_w;
			end
		endcase
	end
endmodule
`default_nettype wire

// ---- tb/adc_result_modify_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module adc_result_modify_sva (
	input wire logic CLOCK_I,
	input wire logic RST_I,
	input wire logic READ_I,
	input wire logic CONV_DONE_I,
	input wire logic CONV_REQ_O,
	input wire logic BUSY_O,
	input wire logic [3:0] QUEUE_LEVEL_O,
	input wire logic READ_ACK_O,
	input wire logic [3:0] READ_COUNT_O,
	input wire logic RESULT_EVENT_O
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RST_I);
	a_read_ack:
	assert property (READ_I |=> READ_ACK_O) else $error("read not acked");
	a_ack_cause:
	assert property (READ_ACK_O |-> $past(READ_I)) else $error("stray ack");
	a_req_single:
	assert property (CONV_REQ_O |=> !CONV_REQ_O) else $error("long request");
	a_req_idle:
	assert property (CONV_REQ_O |-> BUSY_O && !$past(BUSY_O))
		else $error("request while busy");
	a_busy_rise:
	assert property ($rose(BUSY_O) |-> CONV_REQ_O) else $error("busy no req");
	a_busy_drop:
	assert property (BUSY_O && CONV_DONE_I |=> !BUSY_O)
		else $error("busy after done");
	a_event_cause:
	assert property (RESULT_EVENT_O |-> $past(CONV_DONE_I && BUSY_O))
		else $error("event without done");
	a_level_cap:
	assert property (QUEUE_LEVEL_O <= 4'h8) else $error("queue over depth");
	c_event: cover property (RESULT_EVENT_O);
	c_full: cover property (QUEUE_LEVEL_O == 4'h8);
	c_partial: cover property (READ_ACK_O && READ_COUNT_O != 4'h0);
endmodule
bind adc_result_modify adc_result_modify_sva sva_u (.CLOCK_I(CLOCK_I),
	.RST_I(RST_I), .READ_I(READ_I), .CONV_DONE_I(CONV_DONE_I),
	.CONV_REQ_O(CONV_REQ_O), .BUSY_O(BUSY_O), .QUEUE_LEVEL_O(QUEUE_LEVEL_O),
	.READ_ACK_O(READ_ACK_O), .READ_COUNT_O(READ_COUNT_O),
	.RESULT_EVENT_O(RESULT_EVENT_O));
`default_nettype wire

// ---- tb/conv_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module conv_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_i,
	input wire logic [3:0] delay_i,
	input wire logic [11:0] value_i,
	output logic done_o,
	output logic [11:0] data_o
);
	logic [3:0] wait_cnt;
	logic live;
	// twelve bit answer, one per request
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			live <= 1'b0;
			wait_cnt <= 4'h0;
			done_o <= 1'b0;
			data_o <= 12'h000;
		end else begin
			done_o <= 1'b0;
			data_o <= ~data_o;
			if (req_i) begin
				live <= 1'b1;
				wait_cnt <= delay_i;
			end else if (live && wait_cnt == 4'h0) begin
				live <= 1'b0;
				done_o <= 1'b1;
				data_o <= value_i;
			end else if (live) begin
				wait_cnt <= wait_cnt - 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk = 0, rst = 1, map_we = 0, rcr_we = 0, push = 0, refill = 0;
	logic trig = 0, sync = 0, rd = 0, done, req, busy, ack, vld;
	logic [1:0] grp = 0, mode = 0, qgrp = 0, cg;
	logic [3:0] ch = 0, res = 0, idx = 0, ctrl = 0, qch = 0, dly = 1;
	logic [3:0] lvl, cc, rcnt;
	logic [11:0] val = 0, cdata;
	logic [15:0] rdata;
	int failures = 0, n_checks = 0, cycles = 0, nreq = 0;
	int nevt = 0, mark = 0;
	logic ten = 0, tick = 0, evt;
	logic [1:0] egrp = 0, rgrp;
	logic [3:0] eidx = 0, ridx;
	always #5 clk = ~clk;
	conv_model model_u (.clk_i(clk), .rst_i(rst), .req_i(req),
		.delay_i(dly), .value_i(val), .done_o(done), .data_o(cdata));
	adc_result_modify dut_u (.CLOCK_I(clk), .RST_I(rst),
		.CFG_MAP_WE_I(map_we), .CFG_RCR_WE_I(rcr_we), .CFG_GROUP_I(grp),
		.CFG_CHANNEL_I(ch), .CFG_RESULT_I(res), .CFG_INDEX_I(idx),
		.CFG_MODE_I(mode), .CFG_CTRL_I(ctrl), .QUEUE_GROUP_I(qgrp),
		.QUEUE_PUSH_I(push), .QUEUE_CHANNEL_I(qch), .QUEUE_REFILL_I(refill),
		.TRIGGER_I(trig), .TIMER_ENABLE_I(ten), .TIMER_TICK_I(tick),
		.SYNC_REQ_I(sync), .SYNC_GROUP_I(grp), .SYNC_CHANNEL_I(ch),
		.CONV_DONE_I(done), .CONV_DATA_I(cdata), .READ_I(rd),
		.READ_GROUP_I(grp), .READ_INDEX_I(idx), .CONV_REQ_O(req),
		.CONV_GROUP_O(cg), .CONV_CHANNEL_O(cc), .BUSY_O(busy),
		.QUEUE_LEVEL_O(lvl), .READ_ACK_O(ack), .READ_DATA_O(rdata),
		.READ_VALID_O(vld), .READ_COUNT_O(rcnt), .RESULT_EVENT_O(evt),
		.RESULT_GROUP_O(rgrp), .RESULT_INDEX_O(ridx));
	task automatic wrap_up();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] s, e);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cfg(input logic [1:0] g, input logic [3:0] c, r,
		input logic [1:0] m, input logic [3:0] k);
		grp = g;
		ch = c;
		res = r;
		idx = r;
		mode = m;
		ctrl = k;
		map_we = 1;
		rcr_we = 1;
		@(negedge clk);
		map_we = 0;
		rcr_we = 0;
		@(negedge clk);
	endtask
	task automatic wait_conv();
		int i;
		logic seen;
		i = 0;
		while (busy !== 1'b1 && i < 20) begin
			@(negedge clk);
			i++;
		end
		seen = (busy === 1'b1);
		while (busy === 1'b1 && i < 40) begin
			@(negedge clk);
			i++;
		end
		chk("conversion ended", seen && i < 40, 1);
	endtask
	task automatic conv(input logic [1:0] g, input logic [3:0] c,
		input logic [11:0] v);
		qgrp = g;
		qch = c;
		val = v;
		push = 1;
		@(negedge clk);
		push = 0;
		trig = 1;
		@(negedge clk);
		trig = 0;
		wait_conv();
	endtask
	task automatic rdchk(input logic [1:0] g, input logic [3:0] r,
		input logic [15:0] d, input logic v, input logic [3:0] n);
		grp = g;
		idx = r;
		rd = 1;
		@(negedge clk);
		rd = 0;
		chk("ack", ack, 1);
		chk("data", rdata, d);
		chk("valid", vld, v);
		chk("count", rcnt, n);
		@(negedge clk);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (req === 1'b1)
			nreq++;
		if (cycles == 20000) begin
			failures++;
			wrap_up();
		end
	end
	// result events are caught mid-cycle, away from the launching edge
	always @(negedge clk) begin
		if (evt === 1'b1) begin
			nevt++;
			egrp = rgrp;
			eidx = ridx;
		end
	end
	initial begin
		repeat (3) @(negedge clk);
		rst = 0;
		@(negedge clk);
		cfg(0, 3, 2, 0, 0);
		conv(0, 3, 12'h123);
		rdchk(0, 2, 16'h0123, 1, 0);
		rdchk(0, 2, 16'h0123, 0, 0);
		$display("test store done");
		dly = 5;
		cfg(0, 4, 4, 0, 3);
		mark = nevt;
		for (int i = 1; i <= 4; i++) begin
			conv(0, 4, 12'(i * 256));
			if (i == 1)
				rdchk(0, 4, 16'h0100, 0, 3);
		end
		rdchk(0, 4, 16'h0a00, 1, 0);
		chk("events", 16'(nevt - mark), 16'h0001);
		chk("event group", {14'h0, egrp}, 16'h0000);
		chk("event index", {12'h0, eidx}, 16'h0004);
		dly = 1;
		cfg(0, 8, 8, 0, 15);
		repeat (16) conv(0, 8, 12'hfff);
		rdchk(0, 8, 16'hfff0, 1, 0);
		cfg(0, 5, 5, 0, 1);
		conv(0, 5, 12'h010);
		conv(0, 5, 12'h020);
		conv(0, 5, 12'h040);
		rdchk(0, 5, 16'h0040, 1, 1);
		$display("test reduce done");
		cfg(1, 0, 0, 0, 0);
		conv(1, 0, 12'h100);
		cfg(1, 1, 1, 2, 0);
		conv(1, 1, 12'h150);
		rdchk(1, 1, 16'h0050, 1, 0);
		conv(1, 1, 12'h050);
		rdchk(1, 1, 16'hff50, 1, 0);
		cfg(1, 2, 2, 3, 5);
		conv(1, 2, 12'h077);
		rdchk(1, 2, 16'h0077, 1, 0);
		$display("test difference done");
		// history starts at zero, so early outputs are known
		cfg(2, 7, 7, 1, 4'he);
		conv(2, 7, 12'h100);
		conv(2, 7, 12'h100);
		rdchk(2, 7, 16'h0300, 1, 0);
		cfg(2, 15, 15, 1, 4'hf);
		conv(2, 15, 12'h100);
		conv(2, 15, 12'h100);
		rdchk(2, 15, 16'h0600, 1, 0);
		cfg(3, 7, 7, 1, 4'h0);
		conv(3, 7, 12'h010);
		conv(3, 7, 12'h020);
		rdchk(3, 7, 16'h0050, 1, 0);
		cfg(3, 7, 7, 1, 4'hd);
		conv(3, 7, 12'h030);
		rdchk(3, 7, 16'h0060, 1, 0);
		cfg(3, 6, 6, 1, 4'h0);
		conv(3, 6, 12'h0ab);
		rdchk(3, 6, 16'h00ab, 1, 0);
		chk("event group", {14'h0, egrp}, 16'h0003);
		chk("event index", {12'h0, eidx}, 16'h0006);
		$display("test filter done");
		grp = 2;
		ch = 5;
		val = 12'h2a5;
		sync = 1;
		@(negedge clk);
		sync = 0;
		wait_conv();
		chk("sync group", {14'h0, cg}, 16'h0002);
		chk("sync channel", {12'h0, cc}, 16'h0005);
		rdchk(2, 0, 16'h02a5, 1, 0);
		chk("sync event group", {14'h0, egrp}, 16'h0002);
		push = 1;
		repeat (9) @(negedge clk);
		push = 0;
		chk("full level", {12'h0, lvl}, 16'h0008);
		rst = 1;
		repeat (3) @(negedge clk);
		rst = 0;
		@(negedge clk);
		chk("level after reset", {12'h0, lvl}, 16'h0000);
		qgrp = 0;
		qch = 3;
		push = 1;
		@(negedge clk);
		push = 0;
		tick = 1;
		@(negedge clk);
		tick = 0;
		repeat (20) @(negedge clk);
		chk("tick while off", {12'h0, lvl}, 16'h0001);
		ten = 1;
		tick = 1;
		@(negedge clk);
		tick = 0;
		wait_conv();
		ten = 0;
		chk("tick level", {12'h0, lvl}, 16'h0000);
		$display("test timer done");
		refill = 1;
		conv(0, 3, 12'h0f0);
		refill = 0;
		mark = nreq;
		repeat (60) @(negedge clk);
		chk("refill repeats", (nreq - mark) >= 3, 1);
		$display("test queue done");
		wrap_up();
	end
endmodule
`default_nettype wire
